/* File: logic/eth_seg_regs.sv */
// Purpose: AHB-Lite register bank for threshold preset one, segments seven to
//          twelve and the first level, with point-time accumulation.
// Assumes: Single word transfers; writes take the low byte of hwdata.
// Notes:   Data registers have no reset value; outputs stay invalid until all
//          stored registers and the early segment codes have been supplied.
//          Unmapped addresses read as zero and drop writes; no error response.
//
// Behaviour
// - Index 62h holds segment seven code in 7:4, segment eight in 3:0.
// - Index 63h holds segment nine code upper nibble, segment ten lower nibble.
// - Index 64h holds segment eleven code upper nibble, twelve lower nibble.
// - Codes 0 to 15 select 100 up to 8000 microseconds.
// - Index 65h bits 7:3 hold the full five-bit first level.
// - Index 65h bits 2:0 hold bits four to two of second level.
// - Time and level fields have no power-up value; nothing assumed before writes.
// - Index 65h is a level register of preset one, not time codes.
// - Second level bits 1:0 come from bits 7:6 of index 66h.
// - First segment time is absolute; later segments are deltas.
`timescale 1ns/100ps
module eth_seg_regs (
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output      logic                      hreadyout,
	output      logic                      hresp,
	output      logic [31:0]               hrdata,
	input  wire eth_pkg::eth_early_codes_t early_codes,
	input  wire logic                      early_codes_valid,
	output      eth_pkg::eth_preset_s      preset,
	output      eth_pkg::eth_times_t       point_times,
	output      logic                      preset_valid
);
	import eth_pkg::*;

	eth_bus_e                    state_q;
	eth_bus_e                    state_d;
	logic [7:0]                  idx_q;
	logic                        accept;
	logic                        acc_write;
	logic [7:0]                  acc_idx;
	logic                        idx_ok;
	logic [ETH_DATA_W-1:0]       hrdata_q;
	logic [ETH_DATA_W-1:0]       rd_mux;
	logic                        wr_en;
	logic [7:0]                  wr_byte;

	logic [7:0]                  seg7_8_q;
	logic [7:0]                  seg9_10_q;
	logic [7:0]                  seg11_12_q;
	logic [7:0]                  level1_q;
	logic [7:0]                  level2lo_q;
	logic [ETH_REG_CNT-1:0]      written_q;
	logic                        all_ready;
	logic                        rd_load;
	logic [ETH_REG_CNT-1:0]      wr_hit;
	logic [ETH_DATA_W-1:0]       status_word;

	eth_code_t                   seg7_delta_code;
	eth_code_t                   seg8_delta_code;
	eth_code_t                   seg9_delta_code;
	eth_code_t                   seg10_delta_code;
	eth_code_t                   seg11_delta_code;
	eth_code_t                   seg12_delta_code;
	eth_code_t                   first_absolute_time_code;
	logic [ETH_LEVEL_W-1:0]      first_level_value;
	logic [ETH_LEVEL_W-1:0]      second_level_value;

	eth_codes_t                  codes_all;
	eth_times_t                  sum_times;
	eth_preset_s                 preset_d;
	eth_preset_s                 preset_q;
	eth_times_t                  times_q;
	logic                        valid_q;

	// Address phase: a transfer is taken only when the bus is ready and
	// the master drives NONSEQ or SEQ. Byte address bits 1:0 are ignored.
	assign accept    = hsel && hready && ((htrans == ETH_HTRANS_NONSEQ) ||
	                   (htrans == ETH_HTRANS_SEQ));
	assign acc_write = hwrite;
	assign acc_idx   = haddr[ETH_ADDR_W-1:2];
	assign idx_ok    = (haddr[31:ETH_ADDR_W] == '0);

	// Bus phase tracker. A write needs no wait state; a read takes one,
	// because the read mux sits behind a register and its data must be
	// captured before the master samples it.
	always_comb begin
		state_d = state_q;
		case (state_q)
			ETH_BUS_RWAIT: begin
				// Read data is loaded this cycle, so the wait state ends here.
				state_d = ETH_BUS_RDONE;
			end
			ETH_BUS_IDLE, ETH_BUS_WRITE, ETH_BUS_RDONE: begin
				if (accept && acc_write) begin
					state_d = ETH_BUS_WRITE;
				end else if (accept) begin
					state_d = ETH_BUS_RWAIT;
				end else begin
					state_d = ETH_BUS_IDLE;
				end
			end
			default: begin
				state_d = ETH_BUS_IDLE;
			end
		endcase
	end

	// The tracker resets to idle, so the bus shows ready as soon as reset
	// is released and the first transfer may follow at once.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ETH_BUS_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Out-of-range addresses fold onto an index that decodes to nothing.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_q <= 8'h00;
		end else if (accept) begin
			idx_q <= idx_ok ? acc_idx : 8'hFF;
		end
	end

	// One wait state on reads keeps hrdata a flop output and lets a read
	// that follows a write see the value that write just stored.
	assign rd_load   = (state_q == ETH_BUS_RWAIT);
	assign hreadyout = !rd_load;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	// A write lands at the end of its data phase, the only cycle in which
	// hwdata is valid; the index was captured in the address phase.
	assign wr_en   = (state_q == ETH_BUS_WRITE);
	assign wr_byte = hwdata[7:0];

	// One hit line per stored register, used by the storage blocks; the
	// written flags below decode idx_q again on their own.
	always_comb begin
		wr_hit                  = '0;
		wr_hit[ETH_WR_SEG7_8]   = wr_en && (idx_q == ETH_IDX_SEG7_8);
		wr_hit[ETH_WR_SEG9_10]  = wr_en && (idx_q == ETH_IDX_SEG9_10);
		wr_hit[ETH_WR_SEG11_12] = wr_en && (idx_q == ETH_IDX_SEG11_12);
		wr_hit[ETH_WR_LEVEL1]   = wr_en && (idx_q == ETH_IDX_LEVEL1);
		wr_hit[ETH_WR_LEVEL2LO] = wr_en && (idx_q == ETH_IDX_LEVEL2LO);
	end

	// Storage registers carry no reset: their contents are undefined until
	// software writes them, and nothing downstream trusts them before then.
	always_ff @(posedge hclk) begin
		if (wr_hit[ETH_WR_SEG7_8]) begin
			seg7_8_q <= wr_byte;
		end
	end

	always_ff @(posedge hclk) begin
		if (wr_hit[ETH_WR_SEG9_10]) begin
			seg9_10_q <= wr_byte;
		end
	end

	always_ff @(posedge hclk) begin
		if (wr_hit[ETH_WR_SEG11_12]) begin
			seg11_12_q <= wr_byte;
		end
	end

	// Index 65h carries level bits only; it never feeds the time path.
	always_ff @(posedge hclk) begin
		if (wr_hit[ETH_WR_LEVEL1]) begin
			level1_q <= wr_byte;
		end
	end

	// Only bits 7:6 of index 66h are used here; the rest is kept so that
	// the whole byte reads back as written.
	always_ff @(posedge hclk) begin
		if (wr_hit[ETH_WR_LEVEL2LO]) begin
			level2lo_q <= wr_byte;
		end
	end

	// Written flags are only ever set, so no set-against-clear race exists.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			written_q <= '0;
		end else if (wr_en) begin
			if (idx_q == ETH_IDX_SEG7_8) begin
				written_q[ETH_WR_SEG7_8] <= 1'b1;
			end
			if (idx_q == ETH_IDX_SEG9_10) begin
				written_q[ETH_WR_SEG9_10] <= 1'b1;
			end
			if (idx_q == ETH_IDX_SEG11_12) begin
				written_q[ETH_WR_SEG11_12] <= 1'b1;
			end
			if (idx_q == ETH_IDX_LEVEL1) begin
				written_q[ETH_WR_LEVEL1] <= 1'b1;
			end
			if (idx_q == ETH_IDX_LEVEL2LO) begin
				written_q[ETH_WR_LEVEL2LO] <= 1'b1;
			end
		end
	end

	// The early codes arrive from the neighbouring bank on this clock; their
	// valid flag gates the outputs exactly as the written flags do, so a
	// missing neighbour can never leak half a threshold curve.
	assign all_ready = (&written_q) && early_codes_valid;

	// Named fields of the stored bytes; each time byte carries the earlier
	// segment of its pair in the upper nibble.
	assign seg7_delta_code          = seg7_8_q[ETH_HI_NIB_LSB +: ETH_CODE_W];
	assign seg8_delta_code          = seg7_8_q[ETH_LO_NIB_LSB +: ETH_CODE_W];
	assign seg9_delta_code          = seg9_10_q[ETH_HI_NIB_LSB +: ETH_CODE_W];
	assign seg10_delta_code         = seg9_10_q[ETH_LO_NIB_LSB +: ETH_CODE_W];
	assign seg11_delta_code         = seg11_12_q[ETH_HI_NIB_LSB +: ETH_CODE_W];
	assign seg12_delta_code         = seg11_12_q[ETH_LO_NIB_LSB +: ETH_CODE_W];
	assign first_absolute_time_code = early_codes[0];
	assign first_level_value        = level1_q[ETH_L1_LSB +: ETH_LEVEL_W];

	// The second level is split: its upper three bits sit below the first
	// level, its lower two at the top of the next register.
	assign second_level_value = {level1_q[ETH_L2_HI_LSB +: ETH_L2_HI_W],
	                             level2lo_q[ETH_L2_LO_LSB +: ETH_L2_LO_W]};

	// Segments one to six come from the neighbouring bank; only the first of
	// them is an absolute time, all later ones are deltas.
	always_comb begin
		codes_all                  = '0;
		codes_all[ETH_OWN_SEG-1:0] = early_codes;
		codes_all[0]               = first_absolute_time_code;
		codes_all[6]               = seg7_delta_code;
		codes_all[7]               = seg8_delta_code;
		codes_all[8]               = seg9_delta_code;
		codes_all[9]               = seg10_delta_code;
		codes_all[10]              = seg11_delta_code;
		codes_all[11]              = seg12_delta_code;
	end

	// The sum is combinational; it is registered together with the preset
	// snapshot so that times and codes always belong together.
	eth_time_acc u_time_acc (
		.codes       (codes_all),
		.point_times (sum_times)
	);

	always_comb begin
		preset_d                    = '0;
		preset_d.first_level_value  = first_level_value;
		preset_d.second_level_value = second_level_value;
		preset_d.codes              = codes_all;
	end

	// Outputs hold zero until every field has been supplied, so the
	// threshold builder never sees undefined storage. Valid drops one
	// cycle after an input goes missing, while the data stays frozen at
	// its last complete value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= all_ready;
		end
	end

	// Level and code snapshot; it only moves while every input is present.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			preset_q <= '0;
		end else if (all_ready) begin
			preset_q <= preset_d;
		end
	end

	// Point times are taken in the same cycle as the snapshot, so they
	// always describe the codes that the preset output shows.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			times_q <= '0;
		end else if (all_ready) begin
			times_q <= sum_times;
		end
	end

	assign preset       = preset_q;
	assign point_times  = times_q;
	assign preset_valid = valid_q;

	// Status shows which registers were written, the overall ready bit and
	// the time of the last threshold point. It is read only: a write to it
	// decodes to no storage and is dropped.
	always_comb begin
		status_word                                 = '0;
		status_word[ETH_STAT_WR_LSB +: ETH_REG_CNT] = written_q;
		status_word[ETH_STAT_OK_BIT]                = valid_q;
		status_word[ETH_STAT_T_LSB +: ETH_TIME_W]   = times_q[ETH_SEGS-1];
	end

	always_comb begin
		rd_mux = '0;
		case (idx_q)
			ETH_IDX_SEG7_8: begin
				rd_mux[7:0] = seg7_8_q;
			end
			ETH_IDX_SEG9_10: begin
				rd_mux[7:0] = seg9_10_q;
			end
			ETH_IDX_SEG11_12: begin
				rd_mux[7:0] = seg11_12_q;
			end
			ETH_IDX_LEVEL1: begin
				rd_mux[7:0] = level1_q;
			end
			ETH_IDX_LEVEL2LO: begin
				rd_mux[7:0] = level2lo_q;
			end
			ETH_IDX_STATUS: begin
				rd_mux = status_word;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// Read data is captured in the wait state and then stands until the
	// next read loads it, which covers the cycle the master samples.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (rd_load) begin
			hrdata_q <= rd_mux;
		end
	end

endmodule

/* File: logic/eth_pkg.sv */
// Purpose: Shared constants and types for the echo threshold preset segment registers.
// Assumes: AHB-Lite word access, one register per aligned word, data in the low byte.
// Notes:   Register indices are kept as printed; the byte address is four times the index.
package eth_pkg;

	localparam int ETH_DATA_W  = 32;
	localparam int ETH_ADDR_W  = 10;
	localparam int ETH_CODE_W  = 4;
	localparam int ETH_LEVEL_W = 5;
	localparam int ETH_US_W    = 14;
	localparam int ETH_TIME_W  = 17;
	localparam int ETH_SEGS    = 12;
	localparam int ETH_OWN_SEG = 6;
	localparam int ETH_REG_CNT = 5;

	// Register indices; the byte address is the index shifted left by two.
	localparam logic [7:0] ETH_IDX_SEG7_8   = 8'h62;
	localparam logic [7:0] ETH_IDX_SEG9_10  = 8'h63;
	localparam logic [7:0] ETH_IDX_SEG11_12 = 8'h64;
	localparam logic [7:0] ETH_IDX_LEVEL1   = 8'h65;
	localparam logic [7:0] ETH_IDX_LEVEL2LO = 8'h66;
	localparam logic [7:0] ETH_IDX_STATUS   = 8'h70;

	// Write flag positions, one per stored register.
	localparam int ETH_WR_SEG7_8   = 0;
	localparam int ETH_WR_SEG9_10  = 1;
	localparam int ETH_WR_SEG11_12 = 2;
	localparam int ETH_WR_LEVEL1   = 3;
	localparam int ETH_WR_LEVEL2LO = 4;

	// Field positions inside the data byte and the status word.
	localparam int ETH_HI_NIB_LSB  = 4;
	localparam int ETH_LO_NIB_LSB  = 0;
	localparam int ETH_L1_LSB      = 3;
	localparam int ETH_L2_HI_LSB   = 0;
	localparam int ETH_L2_HI_W     = 3;
	localparam int ETH_L2_LO_LSB   = 6;
	localparam int ETH_L2_LO_W     = 2;
	localparam int ETH_STAT_WR_LSB = 0;
	localparam int ETH_STAT_OK_BIT = 7;
	localparam int ETH_STAT_T_LSB  = 8;

	// Delta and absolute time per code, in microseconds (100 .. 8000).
	localparam logic [ETH_US_W-1:0] ETH_CODE_US [16] = '{
		14'h0064, 14'h00C8, 14'h012C, 14'h0190, 14'h0258, 14'h0320, 14'h03E8, 14'h04B0,
		14'h0578, 14'h07D0, 14'h0960, 14'h0C80, 14'h0FA0, 14'h1450, 14'h1900, 14'h1F40
	};

	localparam logic [1:0] ETH_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ETH_HTRANS_SEQ    = 2'h3;

	typedef logic [ETH_CODE_W-1:0]                  eth_code_t;
	typedef logic [ETH_SEGS-1:0][ETH_CODE_W-1:0]    eth_codes_t;
	typedef logic [ETH_OWN_SEG-1:0][ETH_CODE_W-1:0] eth_early_codes_t;
	typedef logic [ETH_SEGS-1:0][ETH_TIME_W-1:0]    eth_times_t;

	typedef struct packed {
		logic [ETH_LEVEL_W-1:0] first_level_value;
		logic [ETH_LEVEL_W-1:0] second_level_value;
		eth_codes_t             codes;
	} eth_preset_s;

	typedef enum logic [1:0] {
		ETH_BUS_IDLE  = 2'b00,
		ETH_BUS_WRITE = 2'b01,
		ETH_BUS_RWAIT = 2'b10,
		ETH_BUS_RDONE = 2'b11
	} eth_bus_e;

endpackage

/* File: logic/eth_time_acc.sv */
// Purpose: Turns twelve segment time codes into twelve threshold point times.
// Assumes: Code one is absolute, codes two to twelve are deltas after the previous point.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module eth_time_acc (
	input  wire eth_pkg::eth_codes_t codes,
	output      eth_pkg::eth_times_t point_times
);
	import eth_pkg::*;

	logic [ETH_SEGS-1:0][ETH_TIME_W-1:0] step_us;

	genvar g;
	generate
		for (g = 0; g < ETH_SEGS; g++) begin : g_seg
			// Each code selects its time from the shared table.
			assign step_us[g] = {{(ETH_TIME_W-ETH_US_W){1'b0}}, ETH_CODE_US[codes[g]]};
			if (g == 0) begin : g_abs
				// The first point is an absolute time, not a delta.
				assign point_times[g] = step_us[g];
			end else begin : g_rel
				// Twelve times 8000 us fits in 17 bits, so no sum can wrap.
				assign point_times[g] = point_times[g-1] + step_us[g];
			end
		end
	endgenerate

endmodule

/* File: verif/eth_seg_monitor.sv */
// Purpose: Bus and output checks for the preset segment bank.
// Assumes: One clock domain; hready is fed from hreadyout.
// Notes:   Watches only the ports of the register bank.
`timescale 1ns/100ps
module eth_seg_monitor
	import eth_pkg::*;
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire eth_early_codes_t early_codes,
	input wire logic             early_codes_valid,
	input wire eth_preset_s      preset,
	input wire eth_times_t       point_times,
	input wire logic             preset_valid
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic acc_rd;
	logic acc_wr;
	assign acc_rd = hsel && hready && htrans[1] && !hwrite;
	assign acc_wr = hsel && hready && htrans[1] && hwrite;
	property p_rd_wait; acc_rd |=> !hreadyout ##1 hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_fast; acc_wr |=> hreadyout; endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
	property p_low_cause; $fell(hreadyout) |-> $past(acc_rd); endproperty
	a_low_cause: assert property (p_low_cause) else $error("stall without read");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_abs;
		preset_valid |-> point_times[0] == 17'(ETH_CODE_US[preset.codes[0]]);
	endproperty
	a_abs: assert property (p_abs) else $error("first point not absolute");
	property p_sum;
		preset_valid |-> point_times[11] == point_times[10] + 17'(ETH_CODE_US[preset.codes[11]]);
	endproperty
	a_sum: assert property (p_sum) else $error("last point not running sum");
	property p_drop; !early_codes_valid |=> !preset_valid; endproperty
	a_drop: assert property (p_drop) else $error("valid held without codes");
	property p_rise; $rose(preset_valid) |-> $past(early_codes_valid); endproperty
	a_rise: assert property (p_rise) else $error("valid rose without codes");
	property p_early; preset_valid |-> preset.codes[5:0] == $past(early_codes); endproperty
	a_early: assert property (p_early) else $error("early codes not passed");
	cover property (acc_rd);
	cover property (acc_wr);
	cover property ($rose(preset_valid));
endmodule
bind eth_seg_regs eth_seg_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .early_codes(early_codes), .early_codes_valid(early_codes_valid),
	.preset(preset), .point_times(point_times), .preset_valid(preset_valid));

/* File: verif/tb.sv */
// Purpose: Directed register and point-time test of the preset segment bank.
// Assumes: One master; hready is the slave's hreadyout.
// Notes:   Checks are taken mid-cycle, where registered outputs are settled.
`timescale 1ns/100ps
module tb;
	import eth_pkg::*;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel = 1'b0;
	logic [31:0]      haddr = 32'h0;
	logic [1:0]       htrans = 2'h0;
	logic             hwrite = 1'b0;
	logic [2:0]       hsize = 3'h2;
	logic [31:0]      hwdata = 32'h0;
	logic             hreadyout;
	logic             hresp;
	logic [31:0]      hrdata;
	logic [31:0]      rd;
	logic [31:0]      s;
	eth_early_codes_t early_codes = '0;
	logic             early_codes_valid = 1'b0;
	eth_preset_s      preset;
	eth_times_t       point_times;
	logic             preset_valid;
	int               n_errors = 0;
	int               total_checks = 0;
	int               cyc = 0;
	int               us_tab [16] = '{100, 200, 300, 400, 600, 800, 1000, 1200, 1400,
		2000, 2400, 3200, 4000, 5200, 6400, 8000};
	logic [7:0]       v [5] = '{8'h7E, 8'hC4, 8'h1F, 8'hB6, 8'h9F};
	logic [3:0]       cd [12] = '{4'h0, 4'h1, 4'hC, 4'h3, 4'hA, 4'h5, 4'h7, 4'hE,
		4'hC, 4'h4, 4'h1, 4'hF};

	always #4 hclk = ~hclk;

	eth_seg_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.early_codes(early_codes), .early_codes_valid(early_codes_valid),
		.preset(preset), .point_times(point_times), .preset_valid(preset_valid));

	task tally_and_finish;
		if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// The slave's ready is read mid-cycle; it comes from a flop and holds until the edge.
	task bus(input logic [31:0] a, input logic wr, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= ETH_HTRANS_NONSEQ;
		hwrite <= wr;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(negedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		@(posedge hclk);
	endtask

	task wr(input logic [7:0] i, input logic [7:0] d);
		bus({22'h0, i, 2'b00}, 1'b1, {24'hA5A5A5, d});
	endtask

	task rdc(input logic [7:0] i, input logic [7:0] e);
		bus({22'h0, i, 2'b00}, 1'b0, 32'h0);
		chk(rd, {24'h0, e});
	endtask

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		for (int k = 0; k < 6; k++) early_codes[k] <= cd[k];
		early_codes_valid <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 4; i++) wr(8'h62 + 8'(i), v[i]);
		@(negedge hclk);
		chk(32'(preset_valid), 32'h0);
		@(posedge hclk);
		wr(8'h66, v[4]);
		// The outputs follow the written flags by one more edge.
		@(posedge hclk);
		@(negedge hclk);
		chk(32'(preset_valid), 32'h1);
		chk(32'(preset.first_level_value), 32'h16);
		chk(32'(preset.second_level_value), 32'h1A);
		chk(32'(preset.codes[11:6]), 32'hF14CE7);
		@(posedge hclk);
		for (int i = 0; i < 5; i++) rdc(8'h62 + 8'(i), v[i]);
		bus({22'h1, 8'h62, 2'b00}, 1'b1, 32'h0);
		rdc(8'h62, 8'h7E);
		rdc(8'h61, 8'h00);
		for (int c = 0; c < 16; c++) begin
			cd[6] = 4'(c);
			cd[7] = 4'(15 - c);
			wr(8'h62, {cd[6], cd[7]});
			@(posedge hclk);
			@(negedge hclk);
			s = 32'h0;
			for (int k = 0; k < 12; k++) begin
				s = s + 32'(us_tab[cd[k]]);
				chk(32'(point_times[k]), s);
			end
			@(posedge hclk);
		end
		bus({22'h0, 8'h70, 2'b00}, 1'b0, 32'h0);
		chk(rd, (s << 8) | 32'h9F);
		early_codes_valid <= 1'b0;
		@(posedge hclk);
		@(negedge hclk);
		chk(32'(preset_valid), 32'h0);
		// A second reset must forget every write even with the codes present.
		@(posedge hclk);
		hresetn <= 1'b0;
		early_codes_valid <= 1'b1;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus({22'h0, 8'h70, 2'b00}, 1'b0, 32'h0);
		chk(rd, 32'h0);
		@(negedge hclk);
		chk(32'(preset_valid), 32'h0);
		chk(32'(point_times[11]), 32'h0);
		tally_and_finish();
	end
endmodule
